//--- hw/sar_adc_bus_read_control.sv
// converter control and bus readout: start gating, busy, output mux
`timescale 1ns/1ps
module sar_adc_bus_read_control #(
  parameter int STEPS = sar_ctl_pkg::CONV_STEPS
) (
  input  wire logic                          sys_clk_i,
  input  wire logic                          reset_i,
  input  wire sar_ctl_pkg::host_ctl_t        host_ctl_i,     // cs_n, rd_n, byte_select
  input  wire logic                          conv_clk_i,     // converter input clock level
  input  wire logic                          comp_hi_i,      // comparator: input above trial
  output logic                               busy_n_o,       // low while converting
  output logic [sar_ctl_pkg::BUS_W-1:0]      result_bus_o,   // data lanes
  output logic [sar_ctl_pkg::BUS_W-1:0]      result_bus_oe_o,// high while driving lanes
  output logic [sar_ctl_pkg::RES_W-1:0]      trial_code_o,   // code presented to the DAC
  output logic                               result_valid_o, // buffered result stream
  input  wire logic                          result_ready_i,
  output logic [sar_ctl_pkg::RES_W-1:0]      result_data_o
);
  localparam int RW = sar_ctl_pkg::RES_W;
  localparam int CW = $clog2(STEPS + 1);

  sar_ctl_pkg::conv_state_t state_r;   // controller state
  logic [RW-1:0] sar_r;                // approximation register
  logic [CW-1:0] bit_idx_r;            // decision still to make
  logic [RW-1:0] latch_r;              // output latch
  logic          clk_d_r;              // previous conversion clock level
  logic          busy_n_r;             // busy output
  logic [RW-1:0] bus_r;                // lane data
  logic [RW-1:0] oe_r;                 // lane enables
  logic          fall;                 // conversion clock fell
  logic          read_act;             // chip select and read both low
  logic          start_req;            // all three strobes low
  logic          fifo_in_ready;        // buffer has room
  logic          fifo_push_r;          // push of a finished result
  logic [RW-1:0] fifo_out_data;
  logic          fifo_out_valid;

  assign fall      = clk_d_r && !conv_clk_i;
  assign read_act  = !host_ctl_i.cs_n && !host_ctl_i.rd_n;            // see [R16]
  assign start_req = read_act && !host_ctl_i.byte_select;             // see [R01] see [R12]

  // lane image for a read: MSB nibble always high lanes
  function automatic logic [RW-1:0] lanes(input logic [RW-1:0] d, input logic hb);
    if (hb) begin
      lanes = {d[RW-1:sar_ctl_pkg::NIB_LO], 4'h0, d[RW-1:sar_ctl_pkg::NIB_LO]}; // see [R12]
    end else begin
      lanes = d;                                                    // see [R07] see [R10]
    end
  endfunction

  // conversion clock edge tracker
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      clk_d_r <= 1'b0;
    end else begin
      clk_d_r <= conv_clk_i;
    end
  end

  // sequencer: start, wait for fall, one decision per fall
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      state_r   <= sar_ctl_pkg::ST_IDLE;
      sar_r     <= sar_ctl_pkg::RESULT_RST;
      bit_idx_r <= '0;
    end else begin
      case (state_r)
        sar_ctl_pkg::ST_IDLE: begin
          // a stalled buffer holds off new starts, not results in flight
          if (start_req && fifo_in_ready) begin
            state_r <= sar_ctl_pkg::ST_SYNC;
            sar_r   <= '0;                                          // see [R13]
          end
        end
        sar_ctl_pkg::ST_SYNC: begin
          if (fall) begin                                           // see [R14]
            state_r   <= sar_ctl_pkg::ST_CONV;
            bit_idx_r <= CW'(STEPS);
            sar_r     <= {1'b1, {(RW-1){1'b0}}};
          end
        end
        sar_ctl_pkg::ST_CONV: begin
          // starts are simply not looked at here
          if (fall) begin                                           // see [R02]
            if (!comp_hi_i) begin
              sar_r[bit_idx_r-1'b1] <= 1'b0;
            end
            if (bit_idx_r > CW'(1)) begin
              sar_r[bit_idx_r-2'd2] <= 1'b1;
            end
            bit_idx_r <= bit_idx_r - 1'b1;
            if (bit_idx_r == CW'(1)) begin
              state_r <= sar_ctl_pkg::ST_DONE;
            end
          end
        end
        sar_ctl_pkg::ST_DONE: begin
          state_r <= sar_ctl_pkg::ST_IDLE;
        end
        default: begin
          state_r <= sar_ctl_pkg::ST_IDLE;
        end
      endcase
    end
  end

  assign trial_code_o = sar_r;

  // output latch: loaded on entry to done, before busy rises
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      latch_r     <= sar_ctl_pkg::RESULT_RST;
      fifo_push_r <= 1'b0;
    end else begin
      fifo_push_r <= 1'b0;
      if (state_r == sar_ctl_pkg::ST_CONV && fall && bit_idx_r == CW'(1)) begin
        latch_r     <= comp_hi_i ? sar_r : (sar_r & ~RW'(1));       // see [R15]
        fifo_push_r <= 1'b1;
      end
    end
  end

  // busy: low from start through the done cycle
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      busy_n_r <= 1'b1;
    end else begin
      busy_n_r <= !((state_r == sar_ctl_pkg::ST_IDLE && start_req && fifo_in_ready)
                  || state_r == sar_ctl_pkg::ST_SYNC
                  || state_r == sar_ctl_pkg::ST_CONV);              // see [R03] see [R04]
    end
  end

  // lanes show the latch; during a start read that is the old result
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      bus_r <= '0;
      oe_r  <= '0;
    end else begin
      bus_r <= lanes(latch_r, host_ctl_i.byte_select);              // see [R05] see [R06]
      oe_r  <= read_act ? '1 : '0;                                  // see [R09] see [R16]
    end
  end

  assign busy_n_o        = busy_n_r;
  assign result_bus_o    = bus_r;                                   // see [R08]
  assign result_bus_oe_o = oe_r;
  assign result_valid_o  = fifo_out_valid;
  assign result_data_o   = fifo_out_data;

  sar_result_fifo #(
    .WIDTH (RW),
    .DEPTH (sar_ctl_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .reset_i     (reset_i),
    .in_valid_i  (fifo_push_r),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (latch_r),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (result_ready_i),
    .out_data_o  (fifo_out_data)
  );

  // checks
  sequence s_start;
    state_r == sar_ctl_pkg::ST_IDLE && start_req && fifo_in_ready;
  endsequence

  // end of conversion: status still low in the push cycle, high one cycle on
  sequence s_busy_release;
    !busy_n_o ##1 busy_n_o;
  endsequence

  a_busy_on_start: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    s_start |=> !busy_n_o) else $error("busy not low after start"); // see [R03]
  a_no_hb_start: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (state_r == sar_ctl_pkg::ST_IDLE && host_ctl_i.byte_select)
      |=> state_r == sar_ctl_pkg::ST_IDLE) else $error("start with byte select"); // see [R12]
  a_no_restart: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (state_r == sar_ctl_pkg::ST_CONV && !fall) |=> state_r == sar_ctl_pkg::ST_CONV)
    else $error("conversion disturbed"); // see [R02]
  a_sar_cleared: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    s_start |=> sar_r == '0) else $error("register not cleared"); // see [R13]
  a_sync_fall: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (state_r == sar_ctl_pkg::ST_SYNC && fall) |=> state_r == sar_ctl_pkg::ST_CONV)
    else $error("conversion did not begin on fall"); // see [R14]
  a_latch_first: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    fifo_push_r |-> s_busy_release) else $error("busy rose before latch"); // see [R15]
  a_msb_lanes: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    oe_r[RW-1] |-> result_bus_o[RW-1:8] == $past(latch_r[RW-1:8])) else $error("msb lanes"); // see [R09]
  a_float_idle: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    $past(host_ctl_i.cs_n || host_ctl_i.rd_n) |-> oe_r == '0) else $error("drive w/o read"); // see [R16]
  a_mid_low: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    $past(host_ctl_i.byte_select) |-> result_bus_o[7:4] == 4'h0) else $error("mid lanes"); // see [R12]
  // a word read shows the whole latch, least significant bit in lane zero
  a_word_lanes: assert property (@(posedge sys_clk_i) disable iff (reset_i) // see [R07]
    (oe_r[0] && !$past(host_ctl_i.byte_select)) |-> result_bus_o == $past(latch_r))
    else $error("word lanes");
  // the done cycle always hands status back
  a_busy_done: assert property (@(posedge sys_clk_i) disable iff (reset_i) // see [R03]
    (state_r == sar_ctl_pkg::ST_DONE) |=> busy_n_o) else $error("busy stuck low");
  // a full buffer holds the sequencer idle, so no result is ever dropped
  a_full_refused: assert property (@(posedge sys_clk_i) disable iff (reset_i) // see [R02]
    (state_r == sar_ctl_pkg::ST_IDLE && !fifo_in_ready) |=> state_r == sar_ctl_pkg::ST_IDLE)
    else $error("start while buffer full");
endmodule // sar_adc_bus_read_control

//--- hw/sar_ctl_pkg.sv
// constants and carrier types for the converter bus-read control block
// Functional notes
// [R01] start needs byte_select, chip select, read low
// [R02] starts ignored while a conversion runs
// [R03] busy low during conversion, high otherwise
// [R04] wait mode: host stalls until result ready
// [R05] no-wait mode: read returns previous result
// [R06] result as 12-bit word or two bytes
// [R07] data right justified in the word
// [R08] byte_select muxes nibble or byte onto low lanes
// [R09] top four lanes always carry result MSBs
// [R10] result is 12-bit natural binary code
// [R11] host should keep bus quiet during conversion
// [R12] byte_select high: middle low, no start
// [R13] start clears approximation register, enables drivers
// [R14] conversion begins next conversion clock falling edge
// [R15] latch result first, then raise busy
// [R16] outputs float when chip select or read high
package sar_ctl_pkg;
  localparam int RES_W      = 12;            // result width
  localparam int BUS_W      = 12;            // data lanes
  localparam int NIB_LO     = 8;             // first bit of upper nibble
  localparam int CONV_STEPS = 12;            // bit decisions per conversion
  localparam int FIFO_DEPTH = 4;             // result buffer depth
  localparam logic [RES_W-1:0] RESULT_RST = 12'h000;

  // controller states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,   // waiting for a start
    ST_SYNC = 2'b01,   // waiting for conversion clock fall
    ST_CONV = 2'b10,   // bit decisions running
    ST_DONE = 2'b11    // latch written, busy about to rise
  } conv_state_t;

  // host-side control strobes: cs_n and rd_n active low, byte_select high selects the high byte
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic byte_select;
  } host_ctl_t;
endpackage

//--- hw/sar_result_fifo.sv
// small result FIFO with valid/ready on both sides
`timescale 1ns/1ps
module sar_result_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 4
) (
  input  wire logic             sys_clk_i,
  input  wire logic             reset_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_r [DEPTH];     // storage
  logic [AW-1:0]    wr_ptr_r;          // write index
  logic [AW-1:0]    rd_ptr_r;          // read index
  logic [AW:0]      count_r;           // fill level
  logic             push;
  logic             pop;

  assign in_ready_o  = (count_r != (AW+1)'(DEPTH));
  assign out_valid_o = (count_r != '0);
  assign out_data_o  = mem_r[rd_ptr_r];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // pointer wrap helper
  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH-1)) ? '0 : p + 1'b1;
  endfunction

  // storage write
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  // pointers and fill level
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= bump(wr_ptr_r);
      end
      if (pop) begin
        rd_ptr_r <= bump(rd_ptr_r);
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // sar_result_fifo

//--- test/sar_host_model.sv
// host bus model and ideal comparator facing the converter control block
`timescale 1ns/1ps
module sar_host_model (
  input  wire logic                   sys_clk_i,
  input  wire logic [11:0]            trial_code_i,
  output sar_ctl_pkg::host_ctl_t      host_ctl_o,
  output logic                        comp_hi_o
);
  logic [11:0] target_r = 12'h000;  // analog input expressed as a code

  // ideal comparator, so a correct search lands exactly on the target
  assign comp_hi_o = (target_r >= trial_code_i);

  // idle bus: both selects high
  initial host_ctl_o = 3'h6;

  // strobes move only at the falling edge; all three low asks for a start
  task automatic drive(input logic cs_n, input logic rd_n, input logic bs);
    @(negedge sys_clk_i);
    host_ctl_o = '{cs_n: cs_n, rd_n: rd_n, byte_select: bs};
  endtask
endmodule // sar_host_model

//--- test/tb_sar_adc_bus_read_control.sv
// self-checking bench for the converter bus-read control block
`timescale 1ns/1ps
module tb_sar_adc_bus_read_control;
  logic                   sys_clk      = 1'h0;  // system clock
  logic                   reset_i      = 1'h1;  // sync reset
  logic                   conv_clk     = 1'h0;  // converter clock level
  logic                   result_ready = 1'h0;  // sink stalls unless draining
  sar_ctl_pkg::host_ctl_t host_ctl;             // strobes from the host model
  logic                   comp_hi;              // comparator answer
  logic                   busy_n;               // converter status
  logic                   result_valid;         // buffered stream valid
  logic [11:0]            bus;                  // data lanes
  logic [11:0]            oe;                   // lane drive enables
  logic [11:0]            trial;                // approximation register
  logic [11:0]            rdata;                // buffered stream data
  int                     error_cnt       = 0;
  int                     samples_checked = 0;
  int                     cycles          = 0;  // hang guard
  logic [11:0]            tab [4] = '{12'hA5C, 12'hFFF, 12'h000, 12'h3C1};

  // clocks: converter clock off both system edges, four system cycles long
  initial forever #2 sys_clk = ~sys_clk;
  initial begin
    #1;
    forever #8 conv_clk = ~conv_clk;
  end

  sar_host_model host_u (.sys_clk_i(sys_clk), .trial_code_i(trial), .host_ctl_o(host_ctl),
    .comp_hi_o(comp_hi));

  sar_adc_bus_read_control dut_u (.sys_clk_i(sys_clk), .reset_i(reset_i),
    .host_ctl_i(host_ctl), .conv_clk_i(conv_clk), .comp_hi_i(comp_hi), .busy_n_o(busy_n),
    .result_bus_o(bus), .result_bus_oe_o(oe), .trial_code_o(trial),
    .result_valid_o(result_valid), .result_ready_i(result_ready), .result_data_o(rdata));

  // verdict in one place
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // guard: six conversions of about 55 cycles plus drains stay well under 2000
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      error_cnt++;
      complete_run();
    end
  end

  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // bounded wait for status to return high, counting low cycles
  task automatic wait_done(output int lo);
    lo = 0;
    while (busy_n !== 1'h1 && lo < 300) begin
      @(negedge sys_clk);
      lo++;
    end
  endtask

  // one wait-state read; poke drops the read strobe mid-run to try a restart
  task automatic conv_wait(input logic [11:0] t, input bit poke);
    int lo;
    host_u.target_r = t;
    host_u.drive(1'h0, 1'h0, 1'h0);
    repeat (2) @(negedge sys_clk);
    chk("busy_n", 12'h000, {11'h000, busy_n});
    chk("oe", 12'hFFF, oe);
    if (poke) begin
      host_u.drive(1'h0, 1'h1, 1'h0);
      host_u.drive(1'h0, 1'h0, 1'h0);
    end
    wait_done(lo);
    chk("busy_len", 12'h001, {11'h000, (lo >= 44 && lo <= 58)});
    chk("result", t, bus);
    host_u.drive(1'h1, 1'h1, 1'h0);
  endtask

  // pop one buffered word with a one-cycle ready pulse
  task automatic drain(input logic [11:0] exp);
    chk("valid", 12'h001, {11'h000, result_valid});
    chk("fifo_data", exp, rdata);
    result_ready = 1'h1;
    @(negedge sys_clk);
    result_ready = 1'h0;
    @(negedge sys_clk);
  endtask

  initial begin
    int lo;
    repeat (5) @(negedge sys_clk);
    reset_i = 1'h0;
    chk("busy_rst", 12'h001, {11'h000, busy_n});
    chk("oe_rst", 12'h000, oe);
    // read strobe alone must neither drive nor start
    host_u.drive(1'h1, 1'h0, 1'h0);
    repeat (2) @(negedge sys_clk);
    chk("oe_cs_high", 12'h000, oe);
    chk("busy_cs_high", 12'h001, {11'h000, busy_n});
    // fill the buffer with four codes, both boundary codes among them, sink stalled
    for (int i = 0; i < 4; i++) conv_wait(tab[i], i == 1);
    // buffer full: start refused, old result still shown
    host_u.target_r = 12'h777;
    host_u.drive(1'h0, 1'h0, 1'h0);
    repeat (3) @(negedge sys_clk);
    chk("busy_full", 12'h001, {11'h000, busy_n});
    chk("bus_full", 12'h3C1, bus);
    host_u.drive(1'h1, 1'h1, 1'h0);
    for (int i = 0; i < 4; i++) drain(tab[i]);
    chk("empty", 12'h000, {11'h000, result_valid});
    // high byte read: nibble on both ends, middle low, no start
    host_u.drive(1'h0, 1'h0, 1'h1);
    repeat (2) @(negedge sys_clk);
    chk("high_byte", 12'h303, bus);
    chk("busy_hbyte", 12'h001, {11'h000, busy_n});
    // no-wait reads: each returns the previous result
    host_u.target_r = 12'h5A7;
    host_u.drive(1'h0, 1'h0, 1'h0);
    repeat (2) @(negedge sys_clk);
    chk("old_result", 12'h3C1, bus);
    host_u.drive(1'h1, 1'h1, 1'h0);
    wait_done(lo);
    host_u.drive(1'h0, 1'h0, 1'h0);
    repeat (2) @(negedge sys_clk);
    chk("new_result", 12'h5A7, bus);
    host_u.drive(1'h1, 1'h1, 1'h0);
    wait_done(lo);
    drain(12'h5A7);
    drain(12'h5A7);
    complete_run();
  end
endmodule // tb_sar_adc_bus_read_control
